// *** verilog/rgl_dev.sv ***
// Purpose: Driver end: shift, internal latch, grayscale frame PWM
// Assumes: Link pins slow against clk, sampled through three flops
// Notes:   Latched words pass a two-entry buffer to the frame logic
// Notes on behaviour
// - Clock idle over 220us starts latch sequence
// - Host sends four data pulses, timed
// - Latch on second falling data edge
// - Host closing gap 200ns plus 10ns each
// - Forwarded latch pulses regenerated 90ns wide
// - External gray clock counts both edges
// - Output on while value exceeds counter
// - Host sets divider zero with external clock
// - Free running starts at first load
// - Free running swaps data at frame end
// - Counter reset restarts frame on load
// - One shot runs one frame then off, with counter reset set
// - Adaptive mode: more segments only when all channel values are high
// - 208-bit word, both edges, forwarded out
// - Resolution field picks 8/12/14/16 bits
// - Style bit selects adaptive or single pulse
// - Restart bit selects counter reset mode
`timescale 1ns/100ps
module rgl_dev #(
  parameter int IDLE_CYC = rgl_pkg::IDLE_CYCLES
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  rgl_link_if.dev                     link,
  output logic                        data_out,
  output logic                        shift_clock_out,
  output logic [rgl_pkg::CHANNELS-1:0] sink_on,
  output logic [15:0]                 command,
  output logic                        frame_start
);
  localparam int W = rgl_pkg::WORD_BITS;
  typedef enum {L_SHIFT, L_ARMED} rgl_lat_t;

  // ==========================================================
  // Pin synchronisers
  logic [2:0] dck_s_r, di_s_r, gck_s_r;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dck_s_r <= 3'h0;
      di_s_r  <= 3'h0;
      gck_s_r <= 3'h0;
    end
    else
    begin
      dck_s_r <= {dck_s_r[1:0], link.shift_clock_in};
      di_s_r  <= {di_s_r[1:0], link.serial_data_in};
      gck_s_r <= {gck_s_r[1:0], link.gray_clock_in};
    end
  end
  logic dck_edge, di_fall, gck_edge;
  assign dck_edge = dck_s_r[2] ^ dck_s_r[1];
  assign di_fall  = di_s_r[2] & ~di_s_r[1];
  assign gck_edge = gck_s_r[2] ^ gck_s_r[1];

  // ==========================================================
  // Shift and latch detection
  rgl_lat_t      ls_r, ls_nxt;
  logic [W-1:0]  sh_r, sh_nxt;
  logic [31:0]   idle_r, idle_nxt;
  logic [2:0]    fall_r, fall_nxt;
  logic [3:0]    rt_r, rt_nxt;
  logic          do_r, do_nxt;
  logic          push;
  logic          in_ready;
  always_comb
  begin
    ls_nxt   = ls_r;
    sh_nxt   = sh_r;
    idle_nxt = idle_r;
    fall_nxt = fall_r;
    rt_nxt   = (rt_r != 4'h0) ? rt_r - 4'h1 : 4'h0;
    do_nxt   = do_r;
    push     = 1'b0;
    if (dck_edge)
    begin
      sh_nxt   = {sh_r[W-2:0], di_s_r[2]};
      do_nxt   = sh_r[W-1];
      idle_nxt = 32'h0;
      ls_nxt   = L_SHIFT;
      fall_nxt = 3'h0;
    end
    else
    begin
      case (ls_r)
        L_SHIFT:
        begin
          if (idle_r >= 32'(IDLE_CYC))
          begin
            ls_nxt = L_ARMED;
            do_nxt = 1'b0;
          end
          else
            idle_nxt = idle_r + 32'h1;
        end
        L_ARMED:
        begin
          if (di_s_r[1] & ~di_s_r[2])
            rt_nxt = 4'(rgl_pkg::RETIME_CYC);
          do_nxt = (rt_nxt != 4'h0);
          if (di_fall)
          begin
            fall_nxt = fall_r + 3'h1;
            if (fall_r == 3'(rgl_pkg::LATCH_FALL - 1))
              push = in_ready;
          end
        end
        default: ls_nxt = L_SHIFT;
      endcase
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ls_r   <= L_SHIFT;
      sh_r   <= '0;
      idle_r <= 32'h0;
      fall_r <= 3'h0;
      rt_r   <= 4'h0;
      do_r   <= 1'b0;
    end
    else
    begin
      ls_r   <= ls_nxt;
      sh_r   <= sh_nxt;
      idle_r <= idle_nxt;
      fall_r <= fall_nxt;
      rt_r   <= rt_nxt;
      do_r   <= do_nxt;
    end
  end
  assign data_out        = do_r;
  assign shift_clock_out = dck_s_r[2];

  // ==========================================================
  // Two-entry buffer of latched words
  logic [W-1:0] buf_r [2];
  logic [W-1:0] buf_nxt [2];
  logic [1:0]   cnt_r, cnt_nxt;
  logic         pop, out_valid;
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  always_comb
  begin
    buf_nxt = buf_r;
    cnt_nxt = cnt_r;
    if (pop)
    begin
      buf_nxt[0] = buf_r[1];
      cnt_nxt    = cnt_nxt - 2'h1;
    end
    if (push)
    begin
      buf_nxt[cnt_nxt[0]] = sh_r;
      cnt_nxt             = cnt_nxt + 2'h1;
    end
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      cnt_r    <= 2'h0;
    end
    else
    begin
      buf_r <= buf_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ==========================================================
  // Frame engine
  logic [W-1:0] act_r, act_nxt;
  logic [19:0]  gs_r, gs_nxt;
  logic [7:0]   div_r, div_nxt;
  logic         run_r, run_nxt;
  logic         fs_nxt, fs_r;
  logic         tick, frame_end, ext, adaptive_density_modulation;
  logic [4:0]   res;
  logic [19:0]  frame_len;
  logic [3:0]   seg_sh;
  logic         all_hi;
  logic [15:0]  cmd;
  assign cmd  = act_r[rgl_pkg::CMD_MSB:rgl_pkg::CMD_LSB];
  assign adaptive_density_modulation = cmd[rgl_pkg::F_ADAPTIVE_DENSITY_MODULATION];
  assign ext  = cmd[rgl_pkg::F_EXT_CLK];
  always_comb
  begin
    case (cmd[rgl_pkg::F_RES_HI:rgl_pkg::F_RES_LO])
      2'h0:    res = 5'd8;
      2'h1:    res = 5'd12;
      2'h2:    res = 5'd14;
      default: res = 5'd16;
    endcase
  end
  assign frame_len = 20'h1 << res;
  always_comb
  begin
    all_hi = 1'b1;
    for (int c = 0; c < rgl_pkg::CHANNELS; c++)
      if ((32'(act_r[c*16 +: 16]) * 32'd100) < (32'(frame_len) * 32'(rgl_pkg::HI_SEG_PCT)))
        all_hi = 1'b0;
    seg_sh = all_hi ? 4'd3 : 4'd1;
  end
  // External clock edges, else divided internal
  assign tick = ext ? gck_edge : (div_r == 8'h0);
  assign frame_end = tick & (gs_r == frame_len - 20'h1);
  always_comb
  begin
    act_nxt = act_r;
    gs_nxt  = gs_r;
    run_nxt = run_r;
    fs_nxt  = 1'b0;
    pop     = 1'b0;
    div_nxt = (div_r == ((8'h1 << cmd[rgl_pkg::F_DIV_HI:rgl_pkg::F_DIV_LO]) - 8'h1))
              ? 8'h0 : div_r + 8'h1;
    if (run_r && tick)
      gs_nxt = frame_end ? 20'h0 : gs_r + 20'h1;
    // Counter reset aborts frame on load
    if (out_valid && cmd[rgl_pkg::F_CNT_RESET] && run_r)
    begin
      pop = 1'b1;
      act_nxt = buf_r[0];
      gs_nxt = 20'h0;
      fs_nxt = 1'b1;
    end
    // Start at first load or frame end
    else if (out_valid && (!run_r || frame_end))
    begin
      pop = 1'b1;
      act_nxt = buf_r[0];
      run_nxt = 1'b1;
      gs_nxt = 20'h0;
      fs_nxt = 1'b1;
    end
    // One shot stops after one frame when counter reset is also set
    else if (frame_end && cmd[rgl_pkg::F_CNT_RESET] && cmd[rgl_pkg::F_ONE_SHOT])
      run_nxt = 1'b0;
    else if (frame_end)
      fs_nxt = 1'b1;
  end
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      act_r <= '0;
      gs_r  <= 20'h0;
      div_r <= 8'h0;
      run_r <= 1'b0;
      fs_r  <= 1'b0;
    end
    else
    begin
      act_r <= act_nxt;
      gs_r  <= gs_nxt;
      div_r <= div_nxt;
      run_r <= run_nxt;
      fs_r  <= fs_nxt;
    end
  end
  assign command     = cmd;
  assign frame_start = fs_r;

  // ==========================================================
  // Per-channel comparators
  logic [19:0] cmp_cnt;
  // Adaptive mode scrambles counter so on-time splits into segments
  assign cmp_cnt = adaptive_density_modulation ? (((gs_r << seg_sh) | (gs_r >> (res - 5'(seg_sh)))) & (frame_len - 20'h1))
                        : gs_r;
  logic [rgl_pkg::CHANNELS-1:0] on_r;
  for (genvar c = 0; c < rgl_pkg::CHANNELS; c++)
  begin : g_ch
    always_ff @(posedge clk)
    begin
      if (!rst_n)
        on_r[c] <= 1'b0;
      else
        on_r[c] <= run_r & ({4'h0, act_r[c*16 +: 16]} > cmp_cnt);
    end
  end
  assign sink_on = on_r;
endmodule // rgl_dev

// *** verilog/rgl_pkg.sv ***
// Purpose: Shared constants for the grayscale frame latch link
// Assumes: 100 MHz system clock on both ends
// Notes:   Serial word is command first, then channel 11 down to 0
package rgl_pkg;
  // ==========================================================
  // Word layout
  localparam int WORD_BITS    = 208;
  localparam int CHANNELS     = 12;
  localparam int GS_BITS      = 16;
  localparam int CMD_MSB      = 207;
  localparam int CMD_LSB      = 192;
  // ==========================================================
  // Command field positions
  localparam int F_RES_HI     = 9;
  localparam int F_RES_LO     = 8;
  localparam int F_DIV_HI     = 7;
  localparam int F_DIV_LO     = 5;
  localparam int F_ADAPTIVE_DENSITY_MODULATION       = 4;
  localparam int F_EXT_CLK    = 3;
  localparam int F_CNT_RESET  = 1;
  localparam int F_ONE_SHOT   = 0;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // ==========================================================
  // Timing, 100 MHz clock
  localparam int CLK_PERIOD_NS   = 10;
  localparam int IDLE_START_US   = 220;
  localparam int IDLE_CYCLES     = (IDLE_START_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int PULSE_HI_NS     = 70;
  localparam int PULSE_HI_CYC    = (PULSE_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int PULSE_LO_NS     = 230;
  localparam int PULSE_LO_CYC    = (PULSE_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int STOP_BASE_NS    = 200;
  localparam int STOP_PER_DEV_NS = 10;
  localparam int RETIME_NS       = 90;
  localparam int RETIME_CYC      = RETIME_NS / CLK_PERIOD_NS;
  localparam int LATCH_PULSES    = 4;
  localparam int LATCH_FALL      = 2;
  localparam int HALF_BIT_CYC    = 4;
  localparam int HI_SEG_PCT      = 75;
  localparam int SEGS_HI         = 8;
  localparam int SEGS_LO         = 2;
endpackage

// *** verilog/rgl_link_if.sv ***
// Purpose: Serial link between controller and driver
// Assumes: Unidirectional wires, no bus contention
// Notes:   Gray clock is optional, driven by the controller
`timescale 1ns/100ps
interface rgl_link_if;
  logic shift_clock_in;
  logic serial_data_in;
  logic gray_clock_in;
  // Controller end
  modport host (output shift_clock_in, output serial_data_in, output gray_clock_in);
  // Driver end
  modport dev  (input shift_clock_in, input serial_data_in, input gray_clock_in);
endinterface

// *** verilog/rgl_host.sv ***
// Purpose: Controller end: shifts a word, idles, sends latch burst
// Assumes: Word handed over with valid and ready
// Notes:   Divides clk to make both link clocks
`timescale 1ns/100ps
module rgl_host #(
  parameter int IDLE_CYC   = rgl_pkg::IDLE_CYCLES,
  parameter int CASCADE_N  = 1,
  parameter int GCK_DIV    = 4
) (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic [rgl_pkg::WORD_BITS-1:0] word_data,
  input  wire logic                          word_valid,
  output logic                               word_ready,
  input  wire logic                          gray_clk_en,
  output logic                               busy,
  rgl_link_if.host                           link
);
  // Extra idle cycles so the far end is armed before the first burst pulse rises
  localparam int ARM_MARGIN = 4;
  localparam int STOP_CYC = (rgl_pkg::STOP_BASE_NS + rgl_pkg::STOP_PER_DEV_NS * CASCADE_N
                            + rgl_pkg::CLK_PERIOD_NS - 1) / rgl_pkg::CLK_PERIOD_NS + 1;
  typedef enum {S_IDLE, S_SHIFT, S_WAIT, S_PHI, S_PLO, S_STOP} rgl_hst_t;
  rgl_hst_t                        st_r, st_nxt;
  logic [rgl_pkg::WORD_BITS-1:0]   sh_r, sh_nxt;
  logic [7:0]                      bit_r, bit_nxt;
  logic [31:0]                     cnt_r, cnt_nxt;
  logic [2:0]                      pul_r, pul_nxt;
  logic                            dck_r, dck_nxt, di_r, di_nxt;
  logic [7:0]                      gdiv_r, gdiv_nxt;
  logic                            gck_r, gck_nxt;

  assign word_ready = (st_r == S_IDLE);
  assign busy       = (st_r != S_IDLE);
  assign link.shift_clock_in = dck_r;
  assign link.serial_data_in = di_r;
  assign link.gray_clock_in  = gck_r;

  // ==========================================================
  // Sequencer next state
  always_comb
  begin
    st_nxt  = st_r;
    sh_nxt  = sh_r;
    bit_nxt = bit_r;
    cnt_nxt = cnt_r + 32'h1;
    pul_nxt = pul_r;
    dck_nxt = dck_r;
    di_nxt  = di_r;
    case (st_r)
      S_IDLE:
      begin
        cnt_nxt = 32'h0;
        if (word_valid)
        begin
          sh_nxt  = word_data;
          bit_nxt = 8'h0;
          di_nxt  = word_data[rgl_pkg::WORD_BITS-1];
          st_nxt  = S_SHIFT;
        end
      end
      S_SHIFT:
      begin
        // Each bit toggles the clock, one bit per edge
        if (cnt_r == 32'(rgl_pkg::HALF_BIT_CYC - 1))
        begin
          cnt_nxt = 32'h0;
          dck_nxt = ~dck_r;
          sh_nxt  = {sh_r[rgl_pkg::WORD_BITS-2:0], 1'b0};
          bit_nxt = bit_r + 8'h1;
          if (bit_r == 8'(rgl_pkg::WORD_BITS - 1))
          begin
            di_nxt = 1'b0;
            st_nxt = S_WAIT;
          end
        end
        else if (cnt_r == 32'(rgl_pkg::HALF_BIT_CYC / 2) && bit_r != 8'h0)
          di_nxt = sh_r[rgl_pkg::WORD_BITS-1];
      end
      S_WAIT:
      begin
        if (cnt_r >= 32'(IDLE_CYC + ARM_MARGIN))
        begin
          cnt_nxt = 32'h0;
          pul_nxt = 3'h0;
          di_nxt  = 1'b1;
          st_nxt  = S_PHI;
        end
      end
      S_PHI:
      begin
        if (cnt_r >= 32'(rgl_pkg::PULSE_HI_CYC))
        begin
          cnt_nxt = 32'h0;
          di_nxt  = 1'b0;
          pul_nxt = pul_r + 3'h1;
          st_nxt  = (pul_r == 3'(rgl_pkg::LATCH_PULSES - 1)) ? S_STOP : S_PLO;
        end
      end
      S_PLO:
      begin
        if (cnt_r >= 32'(rgl_pkg::PULSE_LO_CYC))
        begin
          cnt_nxt = 32'h0;
          di_nxt  = 1'b1;
          st_nxt  = S_PHI;
        end
      end
      S_STOP:
      begin
        if (cnt_r >= 32'(STOP_CYC))
          st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // Gray clock divider
  always_comb
  begin
    gdiv_nxt = gdiv_r + 8'h1;
    gck_nxt  = gck_r;
    if (gdiv_r == 8'(GCK_DIV - 1))
    begin
      gdiv_nxt = 8'h0;
      gck_nxt  = gray_clk_en ? ~gck_r : gck_r;
    end
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r   <= S_IDLE;
      sh_r   <= '0;
      bit_r  <= 8'h0;
      cnt_r  <= 32'h0;
      pul_r  <= 3'h0;
      dck_r  <= 1'b0;
      di_r   <= 1'b0;
      gdiv_r <= 8'h0;
      gck_r  <= 1'b0;
    end
    else
    begin
      st_r   <= st_nxt;
      sh_r   <= sh_nxt;
      bit_r  <= bit_nxt;
      cnt_r  <= cnt_nxt;
      pul_r  <= pul_nxt;
      dck_r  <= dck_nxt;
      di_r   <= di_nxt;
      gdiv_r <= gdiv_nxt;
      gck_r  <= gck_nxt;
    end
  end
endmodule // rgl_host

// *** tb/rgl_chk.sv ***
// Purpose: Wire checks on the controller to driver link
// Assumes: One clock domain, link lines sampled on clk
// Notes:   Helper counters measure idle, low runs and pulses
`timescale 1ns/100ps
module rgl_chk #(
  parameter int IDLE_CYC  = 200,
  parameter int CASCADE_N = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic shift_clock_in,
  input wire logic serial_data_in,
  input wire logic gray_clock_in
);
  localparam int STOP_CYC = (200 + 10 * CASCADE_N) / 10 + 1;
  logic sck_r;
  logic sck_nxt;
  logic di_r;
  logic di_nxt;
  logic sck_chg;
  logic b_rise;
  int   idle_r;
  int   idle_nxt;
  int   lo_r;
  int   lo_nxt;
  int   tog_r;
  int   tog_nxt;
  int   pls_r;
  int   pls_nxt;
  // ==========================================================
  // Wire history
  // Next values: idle run, low run, toggles, burst pulses
  always_comb
  begin
    sck_chg  = shift_clock_in != sck_r;
    b_rise   = serial_data_in && !di_r && idle_r >= IDLE_CYC;
    sck_nxt  = rst_n ? shift_clock_in : 1'b0;
    di_nxt   = rst_n ? serial_data_in : 1'b0;
    idle_nxt = (!rst_n || sck_chg) ? 0 : idle_r + 1;
    lo_nxt   = (!rst_n || serial_data_in) ? 0 : lo_r + 1;
    tog_nxt  = (!rst_n || b_rise) ? 0 : tog_r + int'(sck_chg);
    pls_nxt  = (!rst_n || sck_chg) ? 0 : pls_r + int'(b_rise);
  end
  // Register the history
  always_ff @(posedge clk)
  begin
    sck_r  <= sck_nxt;
    di_r   <= di_nxt;
    idle_r <= idle_nxt;
    lo_r   <= lo_nxt;
    tog_r  <= tog_nxt;
    pls_r  <= pls_nxt;
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_reset_idle;
    $rose(rst_n) |-> !shift_clock_in && !serial_data_in && !gray_clock_in;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("link lines not low after reset");
  property p_idle_first;
    (serial_data_in != di_r) |-> (idle_r < 4) || (idle_r >= IDLE_CYC);
  endproperty
  a_idle_first: assert property (p_idle_first)
    else $error("data line moved before the idle time ran out");
  property p_pulse_high;
    b_rise |-> serial_data_in[*8];
  endproperty
  a_pulse_high: assert property (p_pulse_high)
    else $error("latch pulse high phase too short");
  property p_pulse_low;
    b_rise && pls_r != 0 |-> lo_r >= 24;
  endproperty
  a_pulse_low: assert property (p_pulse_low)
    else $error("latch pulse low phase too short");
  property p_four;
    sck_chg && pls_r != 0 |-> pls_r == 4;
  endproperty
  a_four: assert property (p_four)
    else $error("latch burst without four pulses");
  property p_gap;
    sck_chg && pls_r == 4 |-> lo_r >= STOP_CYC;
  endproperty
  a_gap: assert property (p_gap)
    else $error("closing gap of latch burst too short");
  property p_word_len;
    b_rise && pls_r == 0 |-> tog_r == 208;
  endproperty
  a_word_len: assert property (p_word_len)
    else $error("shift clock toggle count per word wrong");
  property p_bit_period;
    sck_chg |-> ##1 (($stable(shift_clock_in)[*3] ##1 !$stable(shift_clock_in))
      or $stable(shift_clock_in)[*8]);
  endproperty
  a_bit_period: assert property (p_bit_period)
    else $error("shift clock half period not four cycles");
endmodule // rgl_chk

// *** tb/rgl_test.sv ***
// Purpose: Self-checking bench, controller and driver on one link
// Assumes: Short idle parameter, internal divider zero
// Notes:   On-time per channel is summed over one whole frame
`timescale 1ns/100ps
module rgl_test;
  localparam int IDLE = 200;
  localparam int GCK  = 4;
  logic                          clk;
  logic                          rst_n;
  logic [rgl_pkg::WORD_BITS-1:0] word_data;
  logic                          word_valid;
  logic                          word_ready;
  logic                          gray_clk_en;
  logic                          busy;
  logic                          data_out;
  logic                          sck_out;
  logic [rgl_pkg::CHANNELS-1:0]  sink_on;
  logic [15:0]                   command;
  logic                          frame_start;
  int                            n_fail;
  int                            checks_done;
  int                            fs_total;
  int                            fs_win;
  int                            on_cnt [12];
  int                            do_run;
  int                            do_last;
  // ==========================================================
  // Design, link and checker
  rgl_link_if rgl_link_if_i ();
  rgl_host #(.IDLE_CYC(IDLE), .CASCADE_N(1), .GCK_DIV(GCK)) rgl_host_i (.clk(clk), .rst_n(rst_n),
    .word_data(word_data), .word_valid(word_valid), .word_ready(word_ready),
    .gray_clk_en(gray_clk_en), .busy(busy), .link(rgl_link_if_i.host));
  rgl_dev #(.IDLE_CYC(IDLE)) rgl_dev_i (.clk(clk), .rst_n(rst_n), .link(rgl_link_if_i.dev),
    .data_out(data_out), .shift_clock_out(sck_out), .sink_on(sink_on), .command(command),
    .frame_start(frame_start));
  rgl_chk #(.IDLE_CYC(IDLE), .CASCADE_N(1)) rgl_chk_i (.clk(clk), .rst_n(rst_n),
    .shift_clock_in(rgl_link_if_i.shift_clock_in),
    .serial_data_in(rgl_link_if_i.serial_data_in),
    .gray_clock_in(rgl_link_if_i.gray_clock_in));
  // Clock, 10 ns period
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Count every frame start
  always @(posedge clk)
    if (frame_start === 1'b1)
      fs_total <= fs_total + 1;
  // Length of the last high run on the forwarded data line
  always @(posedge clk)
    if (data_out === 1'b1)
      do_run <= do_run + 1;
    else
    begin
      if (do_run != 0)
        do_last <= do_run;
      do_run <= 0;
    end
  // ==========================================================
  // Tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Channel value: zero, full scale, or a spread pattern
  function automatic logic [15:0] val(input int c, input int mask);
    if (c == 0)
      return 16'h0000;
    return (c == 11) ? mask[15:0] : 16'((c * 613 + 5) & mask);
  endfunction
  // Hand one word over and wait until the link is free again
  task automatic send(input logic [15:0] cmd, input int mask);
    int k;
    word_data = '0;
    word_data[rgl_pkg::CMD_MSB:rgl_pkg::CMD_LSB] = cmd;
    for (k = 0; k < 12; k++)
      word_data[k*16 +: 16] = val(k, mask);
    word_valid = 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (word_ready !== 1'b1 && k < 50);
    #1 word_valid = 1'b0;
    k = 0;
    while (word_ready !== 1'b1 && k < 5000)
    begin
      @(posedge clk);
      #1 k++;
    end
    repeat (20) @(posedge clk);
    #1 check(word_ready, 1'b1);
    check(busy, 1'b0);
    check(sck_out, 1'b0);
    check(do_last, rgl_pkg::RETIME_CYC);
  endtask
  // Sum on-cycles per channel and frame starts over a window
  task automatic measure(input int len);
    fs_win = fs_total;
    on_cnt = '{default: 0};
    repeat (len)
    begin
      @(posedge clk);
      #1;
      for (int c = 0; c < 12; c++)
        on_cnt[c] += int'(sink_on[c]);
    end
    fs_win = fs_total - fs_win;
  endtask
  task automatic conclude();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Cut a hang short
  initial
  begin
    #900_000;
    n_fail++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    int          r;
    int          s;
    int          len;
    int          prev;
    int          a;
    int          b;
    logic [15:0] cmd;
    rst_n = 1'b0;
    word_data = '0;
    word_valid = 1'b0;
    gray_clk_en = 1'b0;
    n_fail = 0;
    checks_done = 0;
    fs_total = 0;
    do_run = 0;
    do_last = 0;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    check(sink_on, 12'h000);
    check(command, rgl_pkg::CMD_RESET);
    prev = 0;
    // Free running, internal clock, three depths, both styles at 8 and 12 bits
    for (r = 0; r < 3; r++)
      for (s = 0; s < 2; s++)
      begin
        if (r == 2 && s == 1)
          break;
        len = 1 << (r == 0 ? 8 : r == 1 ? 12 : 14);
        cmd = {6'h00, r[1:0], 3'h0, s[0], 4'h0};
        send(cmd, len - 1);
        repeat (prev + 20) @(posedge clk);
        prev = len;
        #1 check(command, cmd);
        measure(len);
        for (int c = 0; c < 12; c++)
          check(on_cnt[c], val(c, len - 1));
        check(fs_win, 1);
      end
    // One shot, counter reset, external gray clock, divider zero
    gray_clk_en = 1'b1;
    send(16'h000b, 32'hff);
    r = 0;
    while (command !== 16'h000b && r < 20000)
    begin
      @(posedge clk);
      #1 r++;
    end
    check(command, 16'h000b);
    prev = fs_total;
    measure(4000);
    check(on_cnt[11] - on_cnt[6], GCK * (int'(val(11, 255)) - int'(val(6, 255))));
    check(on_cnt[0], 0);
    check(on_cnt[11] > 0, 1'b1);
    a = (on_cnt[11] - on_cnt[6]) * (int'(val(6, 255)) - int'(val(1, 255)));
    b = (on_cnt[6] - on_cnt[1]) * (int'(val(11, 255)) - int'(val(6, 255)));
    check(a, b);
    check(sink_on, 12'h000);
    check(fs_total - prev, 1);
    send(16'h000b, 32'hff);
    check(fs_total - prev, 2);
    // Counter reset, 12-bit: a load during a running frame restarts it at once
    send(16'h010a, 32'hfff);
    check(command, 16'h010a);
    prev = fs_total;
    send(16'h010a, 32'hfff);
    check(fs_total - prev, 1);
    conclude();
  end
endmodule // rgl_test
